// File: rtl/bwt_ctrl_regs.sv
// Bus mode, wake source and periodic timer control registers behind the SPI port.
// Assumes chip_mode, soft_reset_req and restart_req come from logic on clk.
`timescale 1ns/1ps
module bwt_ctrl_regs
    import bwt_pkg::*;
#(
    parameter int MS_CYCLES = TICK_CYCLES  // Clock cycles per 1 ms timer tick
)(
    input wire logic clk,
    input wire logic reset,
    input wire logic spi_clk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic [1:0] chip_mode,
    input wire logic soft_reset_req,
    input wire logic restart_req,
    input wire logic stop_watchdog_disable_a,
    output logic [1:0] can_mode,
    output logic [1:0] lin_channel_one_mode,
    output logic [1:0] lin_channel_two_mode,
    output logic [1:0] lin_channel_three_mode,
    output logic lin_slope_control_on,
    output logic lin_low_slope_select,
    output logic lin_tx_timeout_enable,
    output logic periodic_timer_wake_enable,
    output logic stop_watchdog_disable_b,
    output logic watchdog_stop_off,
    output logic wake_pin_enable,
    output logic [1:0] wake_pin_pull_config,
    output logic [2:0] periodic_timer_period,
    output logic periodic_timer_wake
);
    localparam int PRE_W = $clog2(MS_CYCLES);

    // Tick divider needs at least two cycles to produce a one-cycle enable
    if (MS_CYCLES < 2) begin : g_bad_tick
        $error("MS_CYCLES must be at least 2");
    end

    logic [6:0] frame_addr;  // Address of the current or last frame
    logic frame_write;  // Access bit of that frame
    logic [7:0] frame_data;  // Data byte of the last whole frame
    logic frame_valid;  // One-cycle pulse per whole frame
    logic [2:0] cur_idx;  // Register index hit by frame_addr
    logic [7:0] rd_data;  // Read value of the addressed register
    logic [REG_COUNT-1:0][7:0] regs_q, regs_d;  // Stored writable bits only
    logic low_power;  // Chip sits in Stop or Sleep

    // Map an SPI address to a register index, NO_REG when unmapped
    function automatic logic [2:0] reg_index(input logic [6:0] addr);
        reg_index = NO_REG;
        for (int i = 0; i < REG_COUNT; i++) begin
            if (addr == REG_ADDR[i]) begin
                reg_index = 3'(i);
            end
        end
    endfunction

    // Normal operation is swapped for wake capable while the chip is in Stop or Sleep;
    // receive-only and off pass through, so the host must choose them itself
    function automatic logic [1:0] eff_mode(input logic [1:0] field, input logic lp);
        eff_mode = (lp && field == MODE_NORMAL) ? MODE_WAKE : field;
    endfunction

    // Period code to ms; the reserved code yields zero and stops the timer
    function automatic logic [11:0] period_ms(input logic [2:0] code);
        case (code)
            3'h0: period_ms = PER_10MS;
            3'h1: period_ms = PER_20MS;
            3'h2: period_ms = PER_50MS;
            3'h3: period_ms = PER_100MS;
            3'h4: period_ms = PER_200MS;
            3'h5: period_ms = PER_1S;
            3'h6: period_ms = PER_2S;
            default: period_ms = '0;
        endcase
    endfunction

    bwt_spi_frame u_spi (
        .clk(clk),
        .reset(reset),
        .spi_clk(spi_clk),
        .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi),
        .rd_data(rd_data),
        .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe),
        .frame_addr(frame_addr),
        .frame_write(frame_write),
        .frame_data(frame_data),
        .frame_valid(frame_valid)
    );

    assign cur_idx = reg_index(frame_addr);
    assign low_power = (chip_mode == CHIP_STOP) || (chip_mode == CHIP_SLEEP);

    // Read path: masked so reserved bits can never leak, unmapped reads zero
    assign rd_data = (cur_idx == NO_REG) ? 8'h00 : (regs_q[cur_idx] & WR_MASK[cur_idx]);

    // Register file next state; reset beats restart beats an SPI write
    always_comb begin
        regs_d = regs_q;
        if (reset || soft_reset_req) begin
            regs_d = RESET_VAL;
        end else if (restart_req) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_d[i] = regs_q[i] & RESTART_KEEP[i];
            end
        end else if (frame_valid && frame_write && cur_idx != NO_REG) begin
            // Read-only and reserved positions are dropped at the write
            regs_d[cur_idx] = frame_data & WR_MASK[cur_idx];
        end
    end

    // Register file storage
    always_ff @(posedge clk) begin
        regs_q <= regs_d;
    end

    logic [1:0] can_d, lin_channel_one_mode_d, lin_channel_two_mode_d, lin_channel_three_mode_d, pull_d;
    logic slope_d, lsm_d, txto_d, twk_d, swb_d, wdoff_d, wken_d;
    logic [2:0] per_d;

    // Control outputs; transceiver modes carry the low-power substitution
    always_comb begin
        can_d = eff_mode(regs_q[IDX_BUS_A][CAN_LSB +: 2], low_power);
        lin_channel_one_mode_d = eff_mode(regs_q[IDX_BUS_A][LIN_ONE_LSB +: 2], low_power);
        lin_channel_two_mode_d = eff_mode(regs_q[IDX_BUS_B][LIN_TWO_LSB +: 2], low_power);
        lin_channel_three_mode_d = eff_mode(regs_q[IDX_BUS_B][LIN_THREE_LSB +: 2], low_power);
        slope_d = ~regs_q[IDX_BUS_A][FLASH_BIT];
        lsm_d = regs_q[IDX_BUS_A][LOW_SLOPE_BIT];
        txto_d = regs_q[IDX_BUS_A][TX_TIMEOUT_BIT];
        twk_d = regs_q[IDX_WAKE_TMR][TIMER_WAKE_BIT];
        swb_d = regs_q[IDX_WAKE_TMR][STOP_WD_BIT];
        // Either copy of the disable bit stops the watchdog, only in Stop
        wdoff_d = (chip_mode == CHIP_STOP) && (swb_d || stop_watchdog_disable_a);
        wken_d = regs_q[IDX_WAKE_SRC][WAKE_PIN_BIT];
        pull_d = regs_q[IDX_WAKE_BIAS][PULL_LSB +: 2];
        per_d = regs_q[IDX_PER_TMR][PERIOD_LSB +: 3];
        if (reset) begin
            can_d = MODE_OFF;
            lin_channel_one_mode_d = MODE_OFF;
            lin_channel_two_mode_d = MODE_OFF;
            lin_channel_three_mode_d = MODE_OFF;
            slope_d = 1'b1;
            lsm_d = 1'b0;
            txto_d = 1'b0;
            twk_d = 1'b0;
            swb_d = 1'b0;
            wdoff_d = 1'b0;
            wken_d = 1'b0;
            pull_d = '0;
            per_d = '0;
        end
    end

    // Control output flops
    always_ff @(posedge clk) begin
        can_mode <= can_d;
        lin_channel_one_mode <= lin_channel_one_mode_d;
        lin_channel_two_mode <= lin_channel_two_mode_d;
        lin_channel_three_mode <= lin_channel_three_mode_d;
        lin_slope_control_on <= slope_d;
        lin_low_slope_select <= lsm_d;
        lin_tx_timeout_enable <= txto_d;
        periodic_timer_wake_enable <= twk_d;
        stop_watchdog_disable_b <= swb_d;
        watchdog_stop_off <= wdoff_d;
        wake_pin_enable <= wken_d;
        wake_pin_pull_config <= pull_d;
        periodic_timer_period <= per_d;
    end

    logic [PRE_W-1:0] pre_q, pre_d;  // Cycles within the current ms
    logic [11:0] ms_q, ms_d;  // Whole ms within the current period
    logic wake_q, wake_d;  // Period elapsed pulse
    logic [11:0] period;  // Selected period in ms
    logic timer_run;  // Enabled and period code legal

    assign period = period_ms(regs_q[IDX_PER_TMR][PERIOD_LSB +: 3]);
    assign timer_run = regs_q[IDX_WAKE_TMR][TIMER_WAKE_BIT] && period != 12'h000;

    // Periodic wake timer: ms enable from a divider, then a ms count.
    // A period change takes effect from the next ms tick, not from zero.
    always_comb begin
        pre_d = pre_q;
        ms_d = ms_q;
        wake_d = 1'b0;
        if (reset || !timer_run) begin
            pre_d = '0;
            ms_d = '0;
        end else if (pre_q == PRE_W'(MS_CYCLES - 1)) begin
            pre_d = '0;
            if (ms_q >= period - 12'h001) begin
                ms_d = '0;
                wake_d = 1'b1;
            end else begin
                ms_d = 12'(ms_q + 12'h001);
            end
        end else begin
            pre_d = PRE_W'(pre_q + 1'b1);
        end
    end

    // Timer flops
    always_ff @(posedge clk) begin
        pre_q <= pre_d;
        ms_q <= ms_d;
        wake_q <= wake_d;
    end

    assign periodic_timer_wake = wake_q;

    // Write commit shows two cycles later on the control outputs
    a_flash_slope: assert property (@(posedge clk) disable iff (reset)
        (frame_valid && frame_write && cur_idx == 3'h0 && !soft_reset_req && !restart_req)
        |-> ##2 (lin_slope_control_on == !$past(frame_data[FLASH_BIT], 2)))
        else $error("flash bit did not steer slope control");

    a_low_slope_sel: assert property (@(posedge clk) disable iff (reset)
        (frame_valid && frame_write && cur_idx == 3'h0 && !soft_reset_req && !restart_req)
        |-> ##2 (lin_low_slope_select == $past(frame_data[LOW_SLOPE_BIT], 2)))
        else $error("low-slope select did not follow write");

    a_txto_enable: assert property (@(posedge clk) disable iff (reset)
        (frame_valid && frame_write && cur_idx == 3'h0 && !soft_reset_req && !restart_req)
        |-> ##2 (lin_tx_timeout_enable == $past(frame_data[TX_TIMEOUT_BIT], 2)))
        else $error("tx timeout enable did not follow write");

    a_can_subst: assert property (@(posedge clk) disable iff (reset)
        (low_power && regs_q[IDX_BUS_A][CAN_LSB +: 2] == MODE_NORMAL) |=> (can_mode == MODE_WAKE))
        else $error("CAN not wake capable in low power");

    a_lin_subst: assert property (@(posedge clk) disable iff (reset)
        (low_power && regs_q[IDX_BUS_B][LIN_TWO_LSB +: 2] == MODE_NORMAL) |=> (lin_channel_two_mode == MODE_WAKE))
        else $error("LIN two not wake capable in low power");

    a_normal_restore: assert property (@(posedge clk) disable iff (reset)
        (chip_mode == CHIP_NORMAL) |=> (lin_channel_one_mode == $past(regs_q[IDX_BUS_A][LIN_ONE_LSB +: 2])))
        else $error("LIN one mode not restored in normal");

    a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
        (cur_idx != NO_REG) |-> ((rd_data & ~WR_MASK[cur_idx]) == 8'h00))
        else $error("reserved bit read as one");

    a_reset_value: assert property (@(posedge clk)
        (reset || soft_reset_req) |=> (regs_q[IDX_BUS_A] == 8'h20 && regs_q[IDX_WAKE_SRC] == 8'h01))
        else $error("reset values wrong");

    a_restart_keep: assert property (@(posedge clk) disable iff (reset)
        (restart_req && !soft_reset_req) |=> (regs_q[IDX_WAKE_TMR] == ($past(regs_q[IDX_WAKE_TMR]) & 8'h40)))
        else $error("restart did not clear stop watchdog bit");

    a_period_ignore: assert property (@(posedge clk) disable iff (reset)
        (restart_req && !soft_reset_req) |=> (regs_q[IDX_PER_TMR] == $past(regs_q[IDX_PER_TMR])))
        else $error("restart changed timer period");

    c_write_bus_a: cover property (@(posedge clk) disable iff (reset)
        frame_valid && frame_write && cur_idx == 3'h0);
    c_can_subst: cover property (@(posedge clk) disable iff (reset)
        low_power && regs_q[IDX_BUS_A][CAN_LSB +: 2] == MODE_NORMAL);
    c_restart: cover property (@(posedge clk) disable iff (reset) restart_req);
    c_timer_wake: cover property (@(posedge clk) disable iff (reset) wake_q);
endmodule

// File: include/bwt_pkg.sv
// Shared constants of the bus/wake/timer control register group.
// Assumes one 200 MHz clock and a 16-bit, least-significant-bit-first SPI frame.
package bwt_pkg;
    // Clock and time base
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_TIME_NS = 1000000;  // 1 ms timer tick
    localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

    // SPI frame shape
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] BYTE_BITS = 5'h08;
    localparam logic [2:0] SYNC_IDLE = 3'h2;  // {sclk, cs_n, mosi} while idle

    // Register map, index 0 is the first bus control register
    localparam int REG_COUNT = 6;
    localparam int IDX_BUS_A = 0;
    localparam int IDX_BUS_B = 1;
    localparam int IDX_WAKE_TMR = 2;
    localparam int IDX_WAKE_SRC = 3;
    localparam int IDX_WAKE_BIAS = 4;
    localparam int IDX_PER_TMR = 5;
    localparam logic [2:0] NO_REG = 3'h7;
    localparam logic [REG_COUNT-1:0][6:0] REG_ADDR = {7'h0c, 7'h08, 7'h07, 7'h06, 7'h05, 7'h04};
    localparam logic [REG_COUNT-1:0][7:0] WR_MASK = {8'h07, 8'h03, 8'h01, 8'h44, 8'h1b, 8'hfb};
    localparam logic [REG_COUNT-1:0][7:0] RESET_VAL = {8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h20};
    localparam logic [REG_COUNT-1:0][7:0] RESTART_KEEP = {8'h07, 8'h03, 8'h01, 8'h40, 8'h1b, 8'hfb};

    // Field positions
    localparam int FLASH_BIT = 7;
    localparam int LOW_SLOPE_BIT = 6;
    localparam int TX_TIMEOUT_BIT = 5;
    localparam int LIN_ONE_LSB = 3;
    localparam int CAN_LSB = 0;
    localparam int LIN_THREE_LSB = 3;
    localparam int LIN_TWO_LSB = 0;
    localparam int TIMER_WAKE_BIT = 6;
    localparam int STOP_WD_BIT = 2;
    localparam int WAKE_PIN_BIT = 0;
    localparam int PULL_LSB = 0;
    localparam int PERIOD_LSB = 0;

    // Transceiver modes
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_WAKE = 2'h1;
    localparam logic [1:0] MODE_RX_ONLY = 2'h2;
    localparam logic [1:0] MODE_NORMAL = 2'h3;

    // Chip operating modes as seen on the chip_mode input
    localparam logic [1:0] CHIP_NORMAL = 2'h0;
    localparam logic [1:0] CHIP_STOP = 2'h1;
    localparam logic [1:0] CHIP_SLEEP = 2'h2;

    // Periodic timer periods in ms
    localparam logic [2:0] PERIOD_RESERVED = 3'h7;
    localparam logic [11:0] PER_10MS = 12'h00a;
    localparam logic [11:0] PER_20MS = 12'h014;
    localparam logic [11:0] PER_50MS = 12'h032;
    localparam logic [11:0] PER_100MS = 12'h064;
    localparam logic [11:0] PER_200MS = 12'h0c8;
    localparam logic [11:0] PER_1S = 12'h3e8;
    localparam logic [11:0] PER_2S = 12'h7d0;
endpackage

// File: rtl/bwt_spi_frame.sv
// SPI frame receiver: synchronises the pins, shifts a 16-bit frame, returns read data.
// Assumes mode 0 timing: sample on sclk rise, drive on sclk fall, LSB first.
`timescale 1ns/1ps
module bwt_spi_frame
    import bwt_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic spi_clk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic [7:0] rd_data,
    output logic spi_miso,
    output logic spi_miso_oe,
    output logic [6:0] frame_addr,
    output logic frame_write,
    output logic [7:0] frame_data,
    output logic frame_valid
);
    logic [2:0] sync1_q, sync2_q, prev_q;  // {sclk, cs_n, mosi}
    logic sclk_rise, sclk_fall, cs_active, cs_rise;
    logic [4:0] cnt_q, cnt_d;  // Saturates one above a frame to flag overlong frames
    logic [15:0] sh_q, sh_d;
    logic [6:0] addr_q, addr_d;
    logic wr_q, wr_d;
    logic [7:0] tx_q, tx_d, data_q, data_d;
    logic miso_q, miso_d, valid_q, valid_d;

    // Two-flop pin synchroniser, edges taken from the second stage only
    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_q <= SYNC_IDLE;
            sync2_q <= SYNC_IDLE;
            prev_q <= SYNC_IDLE;
        end else begin
            sync1_q <= {spi_clk, spi_cs_n, spi_mosi};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign sclk_rise = sync2_q[2] & ~prev_q[2];
    assign sclk_fall = ~sync2_q[2] & prev_q[2];
    assign cs_active = ~sync2_q[1];
    assign cs_rise = sync2_q[1] & ~prev_q[1];

    // Frame shifter; a frame counts only if exactly 16 clocks came before cs_n rose
    always_comb begin
        cnt_d = cnt_q;
        sh_d = sh_q;
        addr_d = addr_q;
        wr_d = wr_q;
        tx_d = tx_q;
        miso_d = miso_q;
        valid_d = 1'b0;
        data_d = data_q;
        if (reset) begin
            cnt_d = '0;
            sh_d = '0;
            addr_d = '0;
            wr_d = 1'b0;
            tx_d = '0;
            miso_d = 1'b0;
            data_d = '0;
        end else if (!cs_active) begin
            cnt_d = '0;
            tx_d = '0;
            miso_d = 1'b0;
            if (cs_rise && cnt_q == FRAME_BITS) begin
                valid_d = 1'b1;
                data_d = sh_q[15:8];
            end
        end else if (sclk_rise) begin
            sh_d = {sync2_q[0], sh_q[15:1]};
            if (cnt_q <= FRAME_BITS) begin
                cnt_d = 5'(cnt_q + 5'h01);
            end
            // Address byte complete: 7 address bits, then the access bit
            if (cnt_q == BYTE_BITS - 5'h01) begin
                addr_d = sh_d[14:8];
                wr_d = sh_d[15];
            end
        end else if (sclk_fall) begin
            // Read data goes out during the second byte; first byte returns zeros
            if (cnt_q == BYTE_BITS) begin
                miso_d = rd_data[0];
                tx_d = {1'b0, rd_data[7:1]};
            end else begin
                miso_d = tx_q[0];
                tx_d = {1'b0, tx_q[7:1]};
            end
        end
    end

    // Frame state registers
    always_ff @(posedge clk) begin
        cnt_q <= cnt_d;
        sh_q <= sh_d;
        addr_q <= addr_d;
        wr_q <= wr_d;
        tx_q <= tx_d;
        miso_q <= miso_d;
        valid_q <= valid_d;
        data_q <= data_d;
    end

    assign spi_miso = miso_q;
    assign spi_miso_oe = cs_active;
    assign frame_addr = addr_q;
    assign frame_write = wr_q;
    assign frame_data = data_q;
    assign frame_valid = valid_q;
endmodule

// File: bench/bwt_host_model.sv
// Host controller model: sends 16-bit SPI frames, mode 0, least significant bit first.
// Assumes the device samples mosi on the sclk rise and drives miso after the fall.
`timescale 1ns/1ps
module bwt_host_model (
    input wire logic clk,
    output logic spi_clk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oe
);
    logic oe_mid;  // Output enable seen at the start of the data byte of the last frame
    // Clock stands low and select high outside frames
    initial begin
        spi_clk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
        oe_mid = 1'b0;
    end

    // Let n edges pass, then act just after the last one
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One frame; nbits other than 16 gives a broken frame on purpose
    task automatic xfer(input logic [6:0] addr, input logic wr, input logic [7:0] wdata,
                        input int nbits, output logic [7:0] rdata);
        logic [15:0] frame;
        frame = {wdata, wr, addr};
        rdata = 8'h00;
        tick(1);
        spi_cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            spi_mosi = frame[i];
            // Four clk per half period keeps a margin over the synchronisers
            tick(4);
            if (i >= 8) begin
                rdata[i-8] = spi_miso;
            end
            // The device must be driving miso by the time the data byte starts
            if (i == 8) begin
                oe_mid = spi_miso_oe;
            end
            spi_clk = 1'b1;
            tick(4);
            spi_clk = 1'b0;
        end
        tick(4);
        spi_cs_n = 1'b1;
        // Released data line carries no value, so show the inverse
        spi_mosi = ~spi_mosi;
        // Gap between frames plus the commit latency
        tick(8);
    endtask
endmodule

// File: bench/testbench.sv
// Self-checking bench of the bus mode, wake and timer control registers.
// Assumes the host model as SPI controller and a 4-cycle millisecond tick.
`timescale 1ns/1ps
module testbench;
    import bwt_pkg::*;
    localparam int MS = 4; // Short tick keeps timer runs brief
    `define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin failures++; \
        $display("CHECK FAILED t=%0t %s", $time, msg); end end
    logic clk, reset, spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
    logic [1:0] chip_mode, can, l1, l2, l3, pull;
    logic soft_reset_req, restart_req, wd_a, slope_on, low_slope, txto, tmr_en, wd_b, wd_off, pin_en, tmr_wake;
    logic [2:0] period;
    logic [7:0] d;
    int failures = 0;
    int comparisons = 0;
    int n;
    // Own copies of addresses, reset values and writable masks
    logic [6:0] addr_t [6] = '{7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h0c};
    logic [7:0] rst_t [6] = '{8'h20, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
    logic [7:0] msk_t [6] = '{8'hfb, 8'h1b, 8'h44, 8'h01, 8'h03, 8'h07};

    bwt_ctrl_regs #(.MS_CYCLES(MS)) dut (.clk(clk), .reset(reset), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .chip_mode(chip_mode),
        .soft_reset_req(soft_reset_req), .restart_req(restart_req), .stop_watchdog_disable_a(wd_a),
        .can_mode(can), .lin_channel_one_mode(l1), .lin_channel_two_mode(l2), .lin_channel_three_mode(l3),
        .lin_slope_control_on(slope_on), .lin_low_slope_select(low_slope), .lin_tx_timeout_enable(txto),
        .periodic_timer_wake_enable(tmr_en), .stop_watchdog_disable_b(wd_b), .watchdog_stop_off(wd_off),
        .wake_pin_enable(pin_en), .wake_pin_pull_config(pull), .periodic_timer_period(period),
        .periodic_timer_wake(tmr_wake));
    bwt_host_model host (.clk(clk), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        host.xfer(a, 1'b1, v, 16, d);
    endtask
    task automatic rd(input logic [6:0] a);
        host.xfer(a, 1'b0, 8'h00, 16, d);
    endtask
    // Counts clk edges up to the next timer pulse, bounded
    task automatic wait_pulse();
        n = 0;
        do begin
            tick(1);
            n++;
        end while (tmr_wake !== 1'b1 && n < 300);
    endtask

    task automatic stop_test();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Reset contents, then all-ones writes to see reserved bits stay zero
    task automatic t_regs();
        `CHK(spi_miso_oe, 1'b0, "miso enabled while idle");
        `CHK({slope_on, txto, can}, 4'hc, "outputs after reset");
        for (int i = 0; i < 6; i++) begin
            rd(addr_t[i]);
            `CHK(d, rst_t[i], "reset value");
            `CHK(host.oe_mid, 1'b1, "miso not enabled in frame");
            wr(addr_t[i], 8'hff);
            rd(addr_t[i]);
            `CHK(d, msk_t[i], "reserved bits not zero");
        end
        `CHK({slope_on, low_slope, txto}, 3'h3, "flash and slope bits");
        `CHK({tmr_en, wd_b, pin_en}, 3'h7, "wake enables set");
        wr(7'h04, 8'h00);
        `CHK({slope_on, low_slope, txto}, 3'h4, "slope control back on");
    endtask

    // Every transceiver mode, pull and period code
    task automatic t_codes();
        for (int m = 0; m < 4; m++) begin
            wr(7'h04, {3'b001, m[1:0], 1'b0, m[1:0]});
            wr(7'h05, {3'b000, m[1:0], 1'b0, m[1:0]});
            wr(7'h08, {6'h00, m[1:0]});
            `CHK({can, l1, txto}, {m[1:0], m[1:0], 1'b1}, "can and lin one mode");
            `CHK({l2, l3}, {m[1:0], m[1:0]}, "lin two and three mode");
            `CHK(pull, m[1:0], "pull config");
        end
        for (int p = 0; p < 8; p++) begin
            wr(7'h0c, p[7:0]);
            `CHK(period, p[2:0], "period code");
        end
    endtask

    // Stop and Sleep substitution; host sets receive-only and sleep-safe CAN itself
    task automatic t_low_power();
        wr(7'h04, 8'h1b);
        wr(7'h05, 8'h1a);
        chip_mode = CHIP_STOP;
        tick(3);
        `CHK({can, l1, l2, l3}, 8'h59, "stop substitution");
        rd(7'h04);
        `CHK(d, 8'h1b, "stored field altered");
        chip_mode = CHIP_NORMAL;
        tick(3);
        `CHK({can, l1, l3}, 6'h3f, "normal restored");
        wr(7'h04, 8'h19);
        chip_mode = CHIP_SLEEP;
        tick(3);
        `CHK({can, l1}, 4'h5, "sleep substitution");
        chip_mode = CHIP_NORMAL;
        tick(3);
        `CHK(l1, MODE_NORMAL, "lin one restored");
    endtask

    // Both stop watchdog disable copies
    task automatic t_watchdog();
        wr(7'h06, 8'h04);
        chip_mode = CHIP_STOP;
        tick(3);
        `CHK(wd_off, 1'b1, "first copy ignored");
        wr(7'h06, 8'h00);
        `CHK(wd_off, 1'b0, "watchdog still off");
        wd_a = 1'b1;
        tick(3);
        `CHK(wd_off, 1'b1, "second copy ignored");
        wd_a = 1'b0;
        chip_mode = CHIP_NORMAL;
        tick(3);
    endtask

    // Restart masking, soft reset, broken and foreign frames
    task automatic t_restart();
        wr(7'h06, 8'h44);
        wr(7'h0c, 8'h05);
        restart_req = 1'b1;
        tick(1);
        restart_req = 1'b0;
        tick(2);
        rd(7'h06);
        `CHK(d, 8'h40, "restart wake control");
        rd(7'h0c);
        `CHK(d, 8'h05, "restart period");
        soft_reset_req = 1'b1;
        tick(1);
        soft_reset_req = 1'b0;
        tick(2);
        rd(7'h04);
        `CHK(d, 8'h20, "soft reset value");
        host.xfer(7'h04, 1'b1, 8'hff, 15, d);
        wr(7'h14, 8'hff);
        rd(7'h04);
        `CHK(d, 8'h20, "short or foreign frame applied");
    endtask

    // Timer pulse spacing for 10 ms, then silence when disabled
    task automatic t_timer();
        wr(7'h0c, 8'h00);
        wr(7'h06, 8'h40);
        wait_pulse();
        wait_pulse();
        `CHK(n, 10 * MS, "timer interval");
        wr(7'h06, 8'h00);
        wait_pulse();
        `CHK(n, 300, "pulse while disabled");
    endtask

    // Main sequence
    initial begin
        reset = 1'b1;
        chip_mode = CHIP_NORMAL;
        soft_reset_req = 1'b0;
        restart_req = 1'b0;
        wd_a = 1'b0;
        tick(12);
        reset = 1'b0;
        tick(4);
        t_regs();
        t_codes();
        t_low_power();
        t_watchdog();
        t_restart();
        t_timer();
        stop_test();
    end

    // Watchdog against a hang, well beyond the expected run
    initial begin
        #400000;
        failures++;
        stop_test();
    end
endmodule
